// file: rsc_pkg.sv
// What this block does
// - idle/sleep watchdog expiry clears program counter and stack pointer, sets expiry flag.
// - idle/sleep watchdog expiry sets power-down flag and clears the counters, keeps timers, interrupt enables, ports and level code unchanged.
// - expiry flag and power-down flag live in status, updated by reset type.
// - supply-drop reset in fast/slow mode keeps both flags unchanged.
// - fast/slow watchdog expiry sets expiry flag, keeps power-down flag.
// - idle/sleep watchdog expiry sets both flags to one.
// - power-on reset disables all interrupts and zeroes the program counter.
// - any reset clears watchdog and time bases; watchdog restarts counting at once.
// - power-on reset switches every timer module off.
// - power-on sets port data and direction all ones, pull-high and wake-up zero.
// - power-on points stack pointer at top of hardware stack.
// - supply-drop and normal watchdog resets load defaults, accumulator and table pointers kept.
// - unchanged fields keep value, unknown free, unimplemented bits read zero.
// - valid supply-drop reset sets brownout flag; only software clears it.
// - undefined level code resets after a delay and sets bad level code flag.
package rsc_pkg;
   localparam int unsigned CLK_MHZ         = 40;
   localparam int unsigned SRESET_DELAY_US = 100;
   localparam int unsigned SRESET_CYCLES   = SRESET_DELAY_US * CLK_MHZ;
   localparam int unsigned DLY_W           = 13;
   localparam logic [7:0] LEVEL_CODE_A     = 8'h55;
   localparam logic [7:0] LEVEL_CODE_B     = 8'h33;
   localparam logic [7:0] LEVEL_CODE_C     = 8'h99;
   localparam logic [7:0] LEVEL_CODE_D     = 8'hAA;
   localparam logic [7:0] LEVEL_CODE_POR   = 8'h55;
   localparam logic [7:0] PORT_POR         = 8'hFF;
   localparam logic [7:0] PULL_POR         = 8'h00;
   localparam logic [7:0] SP_TOP           = 8'h07;
   localparam int unsigned NUM_PORTS       = 6;
   localparam logic [2:0] EV_BROWNOUT      = 3'h1;
   localparam logic [2:0] EV_BADCODE       = 3'h2;
   localparam logic [2:0] EV_WDT           = 3'h4;
   localparam logic [2:0] EV_NONE          = 3'h0;

   typedef enum logic [1:0] {RSC_FAST, RSC_SLOW, RSC_IDLE, RSC_SLEEP} rsc_mode_t;
   typedef enum {RSC_RUN, RSC_WAITCODE} rsc_state_t;

   // one-hot reset type seen by the core
   typedef struct packed {
      logic por;
      logic full;
      logic wdt_low_power;
   } rsc_kind_t;

   // per-port defaults the core loads on por and on full resets
   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] pull;
      logic [7:0] wake;
   } rsc_port_t;
endpackage

// file: rsc_delay.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_delay (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   output logic      done
);
   logic [rsc_pkg::DLY_W-1:0] cnt;
   logic [rsc_pkg::DLY_W-1:0] next_cnt;
   logic                      next_done;

   // counts while start holds; done pulses once at terminal count
   always_comb begin
      next_cnt  = '0;
      next_done = 1'b0;
      if (start) begin
         next_cnt = cnt + 1'b1;
         if (cnt == rsc_pkg::DLY_W'(rsc_pkg::SRESET_CYCLES - 1)) begin
            next_done = 1'b1;
            next_cnt  = '0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt  <= '0;
         done <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         done <= next_done;
      end
   end
endmodule
`default_nettype wire

// file: rsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_top (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic                     supply_drop_reset,
   input  wire logic                     watchdog_expiry,
   input  wire rsc_pkg::rsc_mode_t       cpu_mode,
   input  wire logic [31:0]              avs_address,
   input  wire logic                     avs_read,
   input  wire logic                     avs_write,
   input  wire logic [31:0]              avs_writedata,
   input  wire logic [3:0]               avs_byteenable,
   output logic [31:0]                   avs_readdata,
   output logic                          avs_waitrequest,
   output logic                          irq,
   output rsc_pkg::rsc_kind_t            reset_kind,
   output logic                          core_reset,
   output logic                          clear_pc,
   output logic                          clear_sp_top,
   output logic                          clear_sp_zero,
   output logic                          irq_disable_all,
   output logic                          timers_off,
   output logic                          count_clear,
   output rsc_pkg::rsc_port_t            port_default,
   output logic                          watchdog_expiry_flag,
   output logic                          power_down_flag
);
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   // offsets sit on the low address byte; upper address bits are not decoded
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_CTRL   = 8'h04;
   localparam logic [7:0] OFF_LEVEL  = 8'h08;
   localparam logic [7:0] OFF_IRQST  = 8'h0C;
   localparam logic [7:0] OFF_IRQMSK = 8'h10;
   localparam logic [7:0] OFF_CMD    = 8'h14;
   // bit positions inside the status, control and command words
   localparam int unsigned B_EXP = 5;
   localparam int unsigned B_PDF = 4;
   localparam int unsigned B_BRN = 2;
   localparam int unsigned B_BAD = 1;
   localparam int unsigned B_HALT = 0;

   // state, next values and reset cause decode
   logic                 expiry_q, pdf_q, next_expiry, next_pdf;
   logic                 brn_q, bad_q, next_brn, next_bad;
   logic [7:0]           level_q, next_level;
   logic [2:0]           ist_q, next_ist, msk_q, next_msk;
   logic                 ack_q, next_ack;
   logic [31:0]          rd_q, next_rd;
   rsc_pkg::rsc_state_t  st_q, next_st;
   logic                 delay_done;
   logic                 wr_hit, rd_hit;
   logic                 lowpow;
   logic                 drop_ok, wdt_norm, wdt_lp, bad_rst;
   logic                 por_pend, next_por_pend;
   rsc_pkg::rsc_kind_t   next_kind;
   logic                 next_irq;

   // idle and sleep share one watchdog treatment
   assign lowpow = (cpu_mode == rsc_pkg::RSC_IDLE) || (cpu_mode == rsc_pkg::RSC_SLEEP);
   // supply monitor is off in idle/sleep, so a drop only counts in fast/slow
   assign drop_ok  = supply_drop_reset && !lowpow;
   assign bad_rst  = delay_done && (st_q == rsc_pkg::RSC_WAITCODE);
   // priority: power-on, bad level code, supply drop, then watchdog
   assign wdt_norm = watchdog_expiry && !lowpow && !drop_ok && !bad_rst && !por_pend;
   assign wdt_lp   = watchdog_expiry && lowpow && !por_pend;
   // a write lands only at the edge that samples waitrequest low, so exactly once
   assign wr_hit   = avs_write && ack_q;
   assign rd_hit   = avs_read && !ack_q;

   // ----------------------------------------------------------------
   // level code supervisor
   // ----------------------------------------------------------------
   // the delay counter only runs while an undefined code is pending
   rsc_delay u_delay (
      .clk   (clk),
      .rst_n (rst_n),
      .start (st_q == rsc_pkg::RSC_WAITCODE),
      .done  (delay_done)
   );

   // an undefined code may come from noise; it is checked every cycle while running, not while waiting
   always_comb begin
      next_st = st_q;
      unique case (st_q)
         rsc_pkg::RSC_RUN: begin
            if (level_q != rsc_pkg::LEVEL_CODE_A && level_q != rsc_pkg::LEVEL_CODE_B &&
                level_q != rsc_pkg::LEVEL_CODE_C && level_q != rsc_pkg::LEVEL_CODE_D) begin
               next_st = rsc_pkg::RSC_WAITCODE;
            end
         end
         rsc_pkg::RSC_WAITCODE: begin
            // limitation: a code fixed while waiting does not cancel the pending reset
            if (delay_done) begin
               next_st = rsc_pkg::RSC_RUN;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // flags and software registers
   // ----------------------------------------------------------------
   always_comb begin
      next_expiry = expiry_q;
      next_pdf    = pdf_q;
      next_brn    = brn_q;
      next_bad    = bad_q;
      next_level  = level_q;
      next_msk    = msk_q;
      next_ist    = ist_q;
      next_por_pend = 1'b0;
      // software writes first so that hardware sets below win
      if (wr_hit && avs_byteenable[0]) begin
         unique case (avs_address[7:0])
            OFF_STATUS: ;
            OFF_CTRL: begin
               next_brn = brn_q & avs_writedata[B_BRN];
               next_bad = bad_q & avs_writedata[B_BAD];
            end
            OFF_LEVEL:  next_level = avs_writedata[7:0];
            OFF_IRQST:  next_ist   = ist_q & ~avs_writedata[2:0];
            OFF_IRQMSK: next_msk   = avs_writedata[2:0];
            OFF_CMD: begin
               // halt entry sets power-down flag and clears expiry flag
               if (avs_writedata[B_HALT]) begin
                  next_pdf    = 1'b1;
                  next_expiry = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // hardware causes, highest priority first
      if (por_pend) begin
         next_expiry = 1'b0;
         next_pdf    = 1'b0;
      end else if (bad_rst) begin
         next_bad   = 1'b1;
         next_level = rsc_pkg::LEVEL_CODE_POR;
         next_ist   = next_ist | rsc_pkg::EV_BADCODE;
      end else if (drop_ok) begin
         // both status flags left alone on a supply drop
         next_brn = 1'b1;
         next_level = rsc_pkg::LEVEL_CODE_POR;
         next_ist = next_ist | rsc_pkg::EV_BROWNOUT;
      end else if (wdt_norm) begin
         next_expiry = 1'b1;
         next_level  = rsc_pkg::LEVEL_CODE_POR;
         next_ist    = next_ist | rsc_pkg::EV_WDT;
      end else if (wdt_lp) begin
         next_expiry = 1'b1;
         next_pdf    = 1'b1;
         next_ist    = next_ist | rsc_pkg::EV_WDT;
      end
   end

   // ----------------------------------------------------------------
   // core-facing reset controls
   // ----------------------------------------------------------------
   // each term masks the higher causes, so at most one bit is ever set
   always_comb begin
      next_kind.por           = por_pend;
      next_kind.full          = !por_pend && (drop_ok || wdt_norm || bad_rst);
      next_kind.wdt_low_power = !por_pend && !drop_ok && !bad_rst && wdt_lp;
   end

   // bus answer: one wait cycle, then acknowledge
   // ack_q mirrors waitrequest low; read data is fetched in the wait cycle
   always_comb begin
      next_ack = (avs_read || avs_write) && !ack_q;
      next_rd  = rd_q;
      if (rd_hit) begin
         unique case (avs_address[7:0])
            OFF_STATUS: next_rd = {26'h0, expiry_q, pdf_q, 4'h0};
            OFF_CTRL:   next_rd = {29'h0, brn_q, bad_q, 1'b0};
            OFF_LEVEL:  next_rd = {24'h0, level_q};
            OFF_IRQST:  next_rd = {29'h0, ist_q};
            OFF_IRQMSK: next_rd = {29'h0, msk_q};
            default:    next_rd = 32'h0;
         endcase
      end
      // built from next values so irq tracks the registered status and mask
      next_irq = |(next_ist & next_msk);
   end

   // one register stage for all internal state
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q         <= rsc_pkg::RSC_RUN;
         expiry_q     <= 1'b0;
         pdf_q        <= 1'b0;
         brn_q        <= 1'b0;
         bad_q        <= 1'b0;
         level_q      <= rsc_pkg::LEVEL_CODE_POR;
         ist_q        <= rsc_pkg::EV_NONE;
         msk_q        <= rsc_pkg::EV_NONE;
         ack_q        <= 1'b0;
         rd_q         <= 32'h0;
         por_pend     <= 1'b1;
         irq          <= 1'b0;
         reset_kind   <= '0;
      end else begin
         st_q         <= next_st;
         expiry_q     <= next_expiry;
         pdf_q        <= next_pdf;
         brn_q        <= next_brn;
         bad_q        <= next_bad;
         level_q      <= next_level;
         ist_q        <= next_ist;
         msk_q        <= next_msk;
         ack_q        <= next_ack;
         rd_q         <= next_rd;
         por_pend     <= next_por_pend;
         irq          <= next_irq;
         reset_kind   <= next_kind;
      end
   end

   // registered copies for the core; reset controls derive from the one-hot kind, port defaults are fixed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         core_reset      <= 1'b1;
         clear_pc        <= 1'b1;
         clear_sp_top    <= 1'b1;
         clear_sp_zero   <= 1'b0;
         irq_disable_all <= 1'b1;
         timers_off      <= 1'b1;
         count_clear     <= 1'b1;
         port_default    <= '0;
         avs_readdata    <= 32'h0;
         avs_waitrequest <= 1'b1;
         watchdog_expiry_flag <= 1'b0;
         power_down_flag <= 1'b0;
      end else begin
         core_reset      <= next_kind.por || next_kind.full;
         clear_pc        <= next_kind.por || next_kind.full || next_kind.wdt_low_power;
         clear_sp_top    <= next_kind.por || next_kind.full;
         clear_sp_zero   <= next_kind.wdt_low_power;
         irq_disable_all <= next_kind.por || next_kind.full;
         timers_off      <= next_kind.por || next_kind.full;
         count_clear     <= next_kind.por || next_kind.full || next_kind.wdt_low_power;
         port_default    <= '{data: rsc_pkg::PORT_POR, dir: rsc_pkg::PORT_POR,
                              pull: rsc_pkg::PULL_POR, wake: rsc_pkg::PULL_POR};
         avs_readdata    <= next_rd;
         avs_waitrequest <= !next_ack;
         watchdog_expiry_flag <= next_expiry;
         power_down_flag <= next_pdf;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // all checks run on the system clock and sleep through reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   wdt_lp_flags_a: assert property (wdt_lp && !por_pend && !bad_rst |=> expiry_q && pdf_q)
      else $error("low power expiry did not set both flags");
   wdt_norm_keep_a: assert property (wdt_norm |=> expiry_q && pdf_q == $past(pdf_q))
      else $error("normal expiry flags wrong");
   drop_keep_a: assert property (drop_ok && !por_pend && !bad_rst |=> $stable(expiry_q) && $stable(pdf_q) && brn_q)
      else $error("supply drop changed status flags");
   lp_pc_sp_a: assert property (wdt_lp && !por_pend && !drop_ok && !bad_rst |=> clear_pc && clear_sp_zero && !core_reset)
      else $error("low power expiry reset wrong");
   kind_onehot_a: assert property ($onehot0(reset_kind))
      else $error("reset kind not one-hot");
   bad_code_a: assert property (bad_rst |=> bad_q && level_q == rsc_pkg::LEVEL_CODE_POR)
      else $error("bad code reset missing");
   full_clears_a: assert property (reset_kind.full |-> timers_off && irq_disable_all && count_clear)
      else $error("full reset controls missing");
   irq_level_a: assert property (|(ist_q & msk_q) |-> irq)
      else $error("interrupt not raised");
   wait_once_a: assert property (avs_read && !avs_waitrequest |=> avs_waitrequest || !avs_read)
      else $error("bus answered twice");

   // core-facing controls per reset type, then the sticky brownout and bad code flags
   por_controls_a: assert property (reset_kind.por |-> clear_pc && clear_sp_top && irq_disable_all && timers_off)
      else $error("power-on controls missing");
   port_inputs_a: assert property (reset_kind.por |-> port_default.data == rsc_pkg::PORT_POR &&
         port_default.dir == rsc_pkg::PORT_POR && port_default.pull == rsc_pkg::PULL_POR &&
         port_default.wake == rsc_pkg::PULL_POR)
      else $error("power-on port defaults wrong");
   count_restart_a: assert property (reset_kind.por || reset_kind.full || reset_kind.wdt_low_power |-> count_clear)
      else $error("counters not cleared on reset");
   lp_keeps_a: assert property (reset_kind.wdt_low_power |-> !core_reset && !timers_off && !irq_disable_all)
      else $error("low power expiry reset too much");
   full_sp_top_a: assert property (reset_kind.full |-> clear_sp_top && clear_pc && !clear_sp_zero)
      else $error("full reset stack controls wrong");
   brn_sticky_a: assert property (brn_q && !(wr_hit && avs_address[7:0] == OFF_CTRL) |=> brn_q)
      else $error("brownout flag lost without software");
   bad_sticky_a: assert property (bad_q && !(wr_hit && avs_address[7:0] == OFF_CTRL) |=> bad_q)
      else $error("bad code flag lost without software");

   cov_lp_c: cover property (wdt_lp ##1 reset_kind.wdt_low_power);
   cov_drop_c: cover property (drop_ok ##1 reset_kind.full);
   cov_bad_c: cover property (bad_rst);
   cov_irq_c: cover property (irq ##1 !irq);
   cov_norm_c: cover property (wdt_norm ##1 reset_kind.full);
endmodule
`default_nettype wire

// file: rsc_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_core_model (
   input  wire logic               clk,
   input  wire logic               rst_n,
   input  wire logic               clear_pc,
   input  wire logic               clear_sp_top,
   input  wire logic               clear_sp_zero,
   input  wire rsc_pkg::rsc_kind_t reset_kind,
   input  wire rsc_pkg::rsc_port_t port_default,
   output logic [7:0]              pc,
   output logic [7:0]              sp,
   output logic [7:0]              port_data
);
   // ------------------------------------------------------------
   // core state as the reset controller steers it
   // ------------------------------------------------------------
   // pc runs freely so a missed clear shows; port data drifts so a missed load shows
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc        <= 8'h00;
         sp        <= rsc_pkg::SP_TOP;
         port_data <= 8'h00;
      end else begin
         pc <= clear_pc ? 8'h00 : pc + 8'h01;
         if (clear_sp_zero) begin
            sp <= 8'h00;
         end else if (clear_sp_top) begin
            sp <= rsc_pkg::SP_TOP;
         end
         if (reset_kind.por || reset_kind.full) begin
            port_data <= port_default.data;
         end else if (!clear_pc) begin
            port_data <= pc; // low-power expiry leaves it alone
         end
      end
   end
endmodule
`default_nettype wire

// file: reset_state_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none
module reset_state_controller_tb;
   logic               clk, rst_n, supply_drop_reset, watchdog_expiry;
   rsc_pkg::rsc_mode_t cpu_mode;
   logic [31:0]        avs_address, avs_writedata, avs_readdata, rd, v;
   logic               avs_read, avs_write, avs_waitrequest, irq, core_reset, clear_pc;
   logic               clear_sp_top, clear_sp_zero, irq_disable_all, timers_off, count_clear;
   logic               watchdog_expiry_flag, power_down_flag, to_e, pd_e;
   rsc_pkg::rsc_kind_t reset_kind;
   rsc_pkg::rsc_port_t port_default;
   logic [7:0]         pc, sp, port_data;
   int                 error_cnt, checks_done, n;

   rsc_top dut (.clk(clk), .rst_n(rst_n), .supply_drop_reset(supply_drop_reset),
      .watchdog_expiry(watchdog_expiry), .cpu_mode(cpu_mode), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .irq(irq), .reset_kind(reset_kind), .core_reset(core_reset), .clear_pc(clear_pc),
      .clear_sp_top(clear_sp_top), .clear_sp_zero(clear_sp_zero), .irq_disable_all(irq_disable_all),
      .timers_off(timers_off), .count_clear(count_clear), .port_default(port_default),
      .watchdog_expiry_flag(watchdog_expiry_flag), .power_down_flag(power_down_flag));
   rsc_core_model core (.clk(clk), .rst_n(rst_n), .clear_pc(clear_pc), .clear_sp_top(clear_sp_top),
      .clear_sp_zero(clear_sp_zero), .reset_kind(reset_kind), .port_default(port_default),
      .pc(pc), .sp(sp), .port_data(port_data));

   // ------------------------------------------------------------
   // clock, verdict, watchdog
   // ------------------------------------------------------------
   always #12.5 clk = ~clk;

   task automatic results();
      if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // generous: bad-code delay dominates the run
   initial begin
      #(25 * 30000);
      error_cnt++;
      results();
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ------------------------------------------------------------
   // avalon master: hold request until waitrequest sampled low
   // ------------------------------------------------------------
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      int k;
      k = 0;
      @(posedge clk);
      avs_address   <= a;
      avs_writedata <= wd;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      rd = avs_readdata;
      if (k >= 50) cmp(32'h0, 32'h1);
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      cmp(rd, exp);
   endtask

   // ------------------------------------------------------------
   // one reset-cause cycle against the flag model
   // ------------------------------------------------------------
   task automatic ev(input logic d, input logic w, input logic [1:0] m);
      logic       full, lp;
      logic [7:0] pd0;
      lp   = m[1] && w;
      full = !m[1] && (d || w);
      if (lp) {to_e, pd_e} = 2'b11;
      else if (full && !d) to_e = 1'b1; // drop outranks expiry
      @(posedge clk);
      supply_drop_reset <= d;
      watchdog_expiry   <= w;
      cpu_mode          <= rsc_pkg::rsc_mode_t'(m);
      @(posedge clk);
      supply_drop_reset <= 1'b0;
      watchdog_expiry   <= 1'b0;
      #1;
      cmp(32'(reset_kind), {29'h0, 1'b0, full, lp});
      cmp(32'(clear_pc), 32'(full || lp));
      cmp(32'(clear_sp_zero), 32'(lp));
      cmp(32'(count_clear), 32'(full || lp));
      cmp({28'h0, core_reset, irq_disable_all, timers_off, clear_sp_top}, {28'h0, {4{full}}});
      pd0 = port_data;
      cmp({30'h0, watchdog_expiry_flag, power_down_flag}, {30'h0, to_e, pd_e});
      @(posedge clk);
      #1;
      if (full || lp) cmp(32'(pc), 32'h0);
      if (full) cmp(32'(port_data), 32'(rsc_pkg::PORT_POR));
      if (lp) cmp(32'(sp), 32'h0);
      if (lp) cmp(32'(port_data), 32'(pd0));
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      clk = 0; rst_n = 0; supply_drop_reset = 0; watchdog_expiry = 0; cpu_mode = rsc_pkg::RSC_FAST;
      avs_address = 0; avs_read = 0; avs_write = 0; avs_writedata = 0;
      error_cnt = 0; checks_done = 0; to_e = 0; pd_e = 0;
      void'($urandom(32'h234f535c));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      cmp(32'(reset_kind), 32'h4);
      cmp({29'h0, irq_disable_all, timers_off, clear_sp_top}, 32'h7);
      cmp(port_default, 32'hFFFF0000);
      cmp({30'h0, watchdog_expiry_flag, power_down_flag}, 32'h0);
      rdc(32'h08, 32'h55);
      rdc(32'h40, 32'h0);
      // random causes and modes, halt mixed in to move the power-down flag
      repeat (40) begin
         if ($urandom % 6 == 0) begin
            bus(1'b1, 32'h14, 32'h1);
            {to_e, pd_e} = 2'b01;
         end else ev(1'($urandom), 1'($urandom), 2'($urandom));
         rdc(32'h00, {26'h0, to_e, pd_e, 4'h0});
      end
      // brownout flag: hardware sets, writing one keeps, zero clears
      bus(1'b1, 32'h04, 32'h0);
      ev(1'b1, 1'b0, 2'd1);
      rdc(32'h04, 32'h4);
      bus(1'b1, 32'h04, 32'h4);
      rdc(32'h04, 32'h4);
      bus(1'b1, 32'h04, 32'h0);
      rdc(32'h04, 32'h0);
      // interrupt: masked, then unmasked, then cleared
      bus(1'b1, 32'h0C, 32'h7);
      bus(1'b1, 32'h10, 32'h0);
      ev(1'b0, 1'b1, 2'd3);
      cmp(32'(irq), 32'h0);
      rdc(32'h0C, 32'h4);
      bus(1'b1, 32'h10, 32'h4);
      repeat (2) @(posedge clk);
      #1;
      cmp(32'(irq), 32'h1);
      bus(1'b1, 32'h0C, 32'h4);
      repeat (2) @(posedge clk);
      #1;
      cmp(32'(irq), 32'h0);
      // undefined level code: delayed full reset, flag set, code restored
      v = $urandom % 256;
      while (v == 32'h55 || v == 32'h33 || v == 32'h99 || v == 32'hAA) v = $urandom % 256;
      bus(1'b1, 32'h08, v);
      n = 0;
      while (n < 5000 && reset_kind.full !== 1'b1) begin
         @(posedge clk);
         #1;
         n++;
      end
      cmp(32'(n >= rsc_pkg::SRESET_CYCLES - 3 && n <= rsc_pkg::SRESET_CYCLES + 3), 32'h1);
      rdc(32'h04, 32'h2);
      rdc(32'h08, 32'h55);
      results();
   end
endmodule
`default_nettype wire
